// ==== common/sla_pkg.sv ====
// constants for the serial link and alarm settings bank
// assumes one 25 MHz clock and a word-wide register port
package sla_pkg;
   // ****************************************
   // register map (printed network addresses)
   // ****************************************
   localparam int NREG = 16;
   localparam int I_THERM = 0;
   localparam int I_ALARM = 1;
   localparam int I_ZERO = 2;
   localparam int I_HEAT = 3;
   localparam int I_BAUD = 4;
   localparam int I_NODE = 5;
   localparam int I_DLEN = 6;
   localparam int I_PAR = 7;
   localparam int I_STOP = 8;
   localparam int I_ACT = 9;
   localparam int I_TOUT = 10;
   localparam int I_WAIT = 11;
   localparam int I_PROTO = 12;
   localparam int I_SPAN0 = 13;
   localparam logic [15:0] REG_ADDR [NREG] = '{
      16'h1441, 16'h1442, 16'h1443, 16'h1444, 16'h144b, 16'h144c,
      16'h144d, 16'h144e, 16'h144f, 16'h1450, 16'h1451, 16'h1452,
      16'h1453, 16'h1455, 16'h1456, 16'h1457};
   // legal value range of each register
   localparam logic [15:0] REG_MIN [NREG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0001,
      16'h0007, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] REG_MAX [NREG] = '{
      16'h0064, 16'h0002, 16'h2710, 16'h00c8, 16'h0006, 16'h0020,
      16'h0008, 16'h0002, 16'h0002, 16'h0004, 16'h270f, 16'h03e8,
      16'h0001, 16'hfffa, 16'hfffa, 16'hfffa};
   // values after reset
   localparam logic [15:0] REG_RST [NREG] = '{
      16'h0050, 16'h0000, 16'h0000, 16'h0078, 16'h0004, 16'h0001,
      16'h0008, 16'h0000, 16'h0001, 16'h0002, 16'h0000, 16'h0000,
      16'h0000, 16'h1000, 16'h1000, 16'h1000};
   // ****************************************
   // codes
   // ****************************************
   localparam logic [15:0] BAUD_TEST = 16'h0002;
   localparam logic [15:0] BAUD_2400 = 16'h0003;
   localparam logic [15:0] ACT_TRIP = 16'h0000;
   localparam logic [15:0] ACT_DTRIP = 16'h0001;
   localparam logic [15:0] ACT_IGN = 16'h0002;
   localparam logic [15:0] ACT_FREE = 16'h0003;
   localparam logic [15:0] ACT_DSTOP = 16'h0004;
   localparam logic [15:0] ALM_3BIT = 16'h0001;
   localparam logic [15:0] ALM_4BIT = 16'h0002;
   localparam logic [15:0] DLEN_8 = 16'h0008;
   localparam logic [15:0] STOP_2 = 16'h0002;
   localparam int SPAN_SHIFT = 12;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int FAST_BPS = 19200;
   localparam int BIT_CYC = CLK_HZ / FAST_BPS;
   localparam int MS_CYC_DEF = CLK_HZ / 1000;
   localparam int TOUT_STEP_MS = 10;
endpackage : sla_pkg

// ==== src/sla_bank.sv ====
// serial link and alarm settings bank with its own link timing
// assumes all inputs are produced on clock by surrounding logic
`timescale 1ns/1ns
// Function
// - baud codes 2..6, stop bits 1 or 2
// - 7 or 8 data bits, parity none/even/odd
// - answer only messages to own node 1..32
// - five reactions to a communication error
// - silence beyond timeout is communication error
// - wait programmed delay before sending reply
// - alarm code off, 3-bit or 4-bit
// - zero speed at or below level
// - thermal warning at threshold reached
// - heatsink warning at threshold reached
// - each analog input scaled by span
module sla_bank #(
   parameter int MS_CYC = sla_pkg::MS_CYC_DEF,
   parameter int AIN_W = 12
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // holding register port
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [15:0]        reg_addr,
   input  wire logic [15:0]        reg_wdata,
   output logic      [15:0]        reg_rdata,
   output logic                    reg_ack,
   output logic                    reg_err,
   // message framing from the receiver
   input  wire logic               msg_valid,
   input  wire logic [7:0]         msg_node,
   output logic                    msg_accept,
   output logic                    tx_start,
   // character format to the serial engine
   output logic                    baud_tick,
   output logic                    test_mode,
   output logic                    data_bits8,
   output logic      [1:0]         parity_mode,
   output logic                    two_stop,
   // communication error reaction
   input  wire logic               motor_stopped,
   input  wire logic               trip_reset,
   output logic                    comm_error,
   output logic                    trip_req,
   output logic                    decel_req,
   output logic                    coast_req,
   // alarm code terminals
   input  wire logic [3:0]         trip_code,
   output logic      [3:0]         alarm_out,
   // warnings
   input  wire logic [15:0]        out_freq,
   input  wire logic [6:0]         thermal_level,
   input  wire logic [7:0]         heatsink_temp,
   output logic                    zero_speed,
   output logic                    thermal_warning_flag,
   output logic                    heatsink_warn,
   // analog inputs and scaled results
   input  wire logic [AIN_W-1:0]   ain_voltage,
   input  wire logic [AIN_W-1:0]   ain_current,
   input  wire logic [AIN_W-1:0]   ain_second,
   output logic      [15:0]        scaled_voltage,
   output logic      [15:0]        scaled_current,
   output logic      [15:0]        scaled_second
);
   import sla_pkg::*;

   // ****************************************
   // decode helpers
   // ****************************************
   // map a network address to a register index
   function automatic logic [4:0] addr_idx(input logic [15:0] a);
      logic [4:0] r;
      r = 5'h1f;
      for (int i = 0; i < NREG; i++) begin
         if (a == REG_ADDR[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction : addr_idx

   // ****************************************
   // register storage
   // ****************************************
   logic [15:0] cfg_q [NREG];      // settings
   logic [4:0]  idx;               // decoded index
   logic        hit;               // mapped address
   logic        in_range;          // write value legal
   logic [15:0] sel_val;           // addressed setting, seen by checks

   assign idx = addr_idx(reg_addr);
   assign hit = (idx != 5'h1f);
   assign sel_val = cfg_q[idx[3:0]];
   assign in_range = hit && reg_wdata >= REG_MIN[idx[3:0]]
                         && reg_wdata <= REG_MAX[idx[3:0]];

   // settings update; an illegal value leaves the old one
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < NREG; i++) begin
            cfg_q[i] <= REG_RST[i];
         end
      end else if (reg_wr && in_range) begin
         cfg_q[idx[3:0]] <= reg_wdata;
      end
   end

   // read data and answer one cycle after the request
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
         reg_ack <= 1'b0;
         reg_err <= 1'b0;
      end else begin
         reg_ack <= reg_wr || reg_rd;
         reg_err <= (reg_wr && !in_range) || (reg_rd && !hit);
         reg_rdata <= (reg_rd && hit) ? cfg_q[idx[3:0]] : 16'h0000;
      end
   end

   // ****************************************
   // time bases
   // ****************************************
   logic [15:0] bit_cnt_q;         // fastest bit period
   logic [2:0]  pre_q;             // prescale for slower rates
   logic [2:0]  pre_max;           // last prescale step
   logic [31:0] ms_cnt_q;          // millisecond divider
   logic        ms_tick_q;         // one-cycle 1 ms pulse
   logic [3:0]  ten_q;             // ten ms divider
   logic        ten_tick_q;        // one-cycle 10 ms pulse

   // slower rates are the 19200 rate divided by 2, 4, 8
   always_comb begin
      case (cfg_q[I_BAUD])
         BAUD_2400: pre_max = 3'h7;
         16'h0004:  pre_max = 3'h3;
         16'h0005:  pre_max = 3'h1;
         default:   pre_max = 3'h0;
      endcase
   end

   // bit rate enable pulse; test mode keeps it still
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bit_cnt_q <= 16'h0000;
         pre_q <= 3'h0;
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= 1'b0;
         if (bit_cnt_q == 16'(BIT_CYC - 1)) begin
            bit_cnt_q <= 16'h0000;
            if (pre_q >= pre_max) begin
               pre_q <= 3'h0;
               baud_tick <= (cfg_q[I_BAUD] != BAUD_TEST);
            end else begin
               pre_q <= pre_q + 3'h1;
            end
         end else begin
            bit_cnt_q <= bit_cnt_q + 16'h0001;
         end
      end
   end

   // millisecond and ten millisecond pulses
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ms_cnt_q <= 32'h0000_0000;
         ms_tick_q <= 1'b0;
         ten_q <= 4'h0;
         ten_tick_q <= 1'b0;
      end else begin
         ms_tick_q <= (ms_cnt_q == 32'(MS_CYC - 1));
         ten_tick_q <= 1'b0;
         if (ms_cnt_q == 32'(MS_CYC - 1)) begin
            ms_cnt_q <= 32'h0000_0000;
         end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
         end
         if (ms_tick_q) begin
            if (ten_q == 4'(TOUT_STEP_MS - 1)) begin
               ten_q <= 4'h0;
               ten_tick_q <= 1'b1;
            end else begin
               ten_q <= ten_q + 4'h1;
            end
         end
      end
   end

   // ****************************************
   // character format
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         test_mode <= 1'b0;
         data_bits8 <= 1'b1;
         parity_mode <= 2'h0;
         two_stop <= 1'b0;
      end else begin
         test_mode <= (cfg_q[I_BAUD] == BAUD_TEST);
         two_stop <= (cfg_q[I_STOP] == STOP_2);
         data_bits8 <= (cfg_q[I_DLEN] == DLEN_8);
         parity_mode <= cfg_q[I_PAR][1:0];
      end
   end

   // ****************************************
   // message acceptance and reply delay
   // ****************************************
   logic [15:0] wait_q;            // ms left before reply
   logic        waiting_q;         // reply pending

   // a reply is never started while an earlier one still waits
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         msg_accept <= 1'b0;
         tx_start <= 1'b0;
         wait_q <= 16'h0000;
         waiting_q <= 1'b0;
      end else begin
         msg_accept <= msg_valid && (msg_node == cfg_q[I_NODE][7:0]);
         tx_start <= 1'b0;
         if (msg_accept) begin
            waiting_q <= 1'b1;
            // one extra step, so a partial first millisecond never shortens the wait
            wait_q <= (cfg_q[I_WAIT] == 16'h0000) ? 16'h0000 : cfg_q[I_WAIT] + 16'h0001;
         end else if (waiting_q) begin
            if (wait_q == 16'h0000) begin
               waiting_q <= 1'b0;
               tx_start <= 1'b1;
            end else if (ms_tick_q) begin
               wait_q <= wait_q - 16'h0001;
            end
         end
      end
   end

   // ****************************************
   // communication watchdog
   // ****************************************
   logic [15:0] idle_q;            // 10 ms steps since message
   logic        lapse;             // timeout exceeded

   assign lapse = (cfg_q[I_TOUT] != 16'h0000) && (idle_q > cfg_q[I_TOUT]);

   // a zero timeout disables the watchdog
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         idle_q <= 16'h0000;
         comm_error <= 1'b0;
      end else begin
         if (msg_accept) begin
            idle_q <= 16'h0000;
         end else if (ten_tick_q && !lapse) begin
            idle_q <= idle_q + 16'h0001;
         end
         // the lapse sets it, a message accepted while no lapse is present clears it
         comm_error <= lapse || (comm_error && !msg_accept);
      end
   end

   // ****************************************
   // error reaction sequencer
   // ****************************************
   typedef enum logic [4:0] {
      ST_RUN   = 5'b00001,
      ST_DECEL = 5'b00010,
      ST_TRIP  = 5'b00100,
      ST_FREE  = 5'b01000,
      ST_HALT  = 5'b10000
   } sla_state_t;
   sla_state_t st_q;               // reaction state

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q <= ST_RUN;
      end else begin
         case (st_q)
            ST_RUN: begin
               if (lapse) begin
                  case (cfg_q[I_ACT])
                     ACT_TRIP:  st_q <= ST_TRIP;
                     ACT_DTRIP: st_q <= ST_DECEL;
                     ACT_FREE:  st_q <= ST_FREE;
                     ACT_DSTOP: st_q <= ST_DECEL;
                     default:   st_q <= ST_RUN;
                  endcase
               end
            end
            ST_DECEL: begin
               if (motor_stopped) begin
                  st_q <= (cfg_q[I_ACT] == ACT_DTRIP) ? ST_TRIP : ST_HALT;
               end
            end
            // a trip is held until cleared from outside
            ST_TRIP: if (trip_reset) begin
               st_q <= ST_RUN;
            end
            ST_FREE, ST_HALT: if (msg_accept) begin
               st_q <= ST_RUN;
            end
            default: st_q <= ST_RUN;
         endcase
      end
   end

   // requests to the drive, registered
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         trip_req <= 1'b0;
         decel_req <= 1'b0;
         coast_req <= 1'b0;
      end else begin
         trip_req <= (st_q == ST_TRIP);
         decel_req <= (st_q == ST_DECEL) || (st_q == ST_HALT);
         coast_req <= (st_q == ST_FREE);
      end
   end

   // ****************************************
   // alarm code and warnings
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         alarm_out <= 4'h0;
         zero_speed <= 1'b0;
         thermal_warning_flag <= 1'b0;
         heatsink_warn <= 1'b0;
      end else begin
         case (cfg_q[I_ALARM])
            ALM_3BIT: alarm_out <= {1'b0, trip_code[2:0]};
            ALM_4BIT: alarm_out <= trip_code;
            default:  alarm_out <= 4'h0;
         endcase
         zero_speed <= (out_freq <= cfg_q[I_ZERO]);
         thermal_warning_flag <= ({9'h000, thermal_level} >= cfg_q[I_THERM]);
         heatsink_warn <= ({8'h00, heatsink_temp} >= cfg_q[I_HEAT]);
      end
   end

   // ****************************************
   // analog span scaling
   // ****************************************
   logic [AIN_W-1:0] ain [3];      // inputs by channel
   logic [15:0]      scl_q [3];    // scaled results
   assign ain[0] = ain_voltage;
   assign ain[1] = ain_current;
   assign ain[2] = ain_second;

   // the product is saturated rather than wrapped
   for (genvar g = 0; g < 3; g++) begin : g_span
      logic [AIN_W+15:0] prod;
      assign prod = ain[g] * cfg_q[I_SPAN0 + g];
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            scl_q[g] <= 16'h0000;
         end else if ((prod >> (SPAN_SHIFT + 16)) != '0) begin
            scl_q[g] <= 16'hffff;
         end else begin
            scl_q[g] <= prod[SPAN_SHIFT+15:SPAN_SHIFT];
         end
      end
   end
   assign scaled_voltage = scl_q[0];
   assign scaled_current = scl_q[1];
   assign scaled_second = scl_q[2];

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_wr_keep;
      reg_wr && hit && !in_range |=> cfg_q[$past(idx[3:0])] == $past(sel_val) && reg_err;
   endproperty
   a_wr_keep: assert property (p_wr_keep) else $error("illegal write stored");

   property p_node;
      msg_valid && msg_node != cfg_q[I_NODE][7:0] |=> !msg_accept;
   endproperty
   a_node: assert property (p_node) else $error("foreign node accepted");

   property p_zero_wait;
      msg_accept && cfg_q[I_WAIT] == 16'h0000 |=> ##1 tx_start;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("reply not started");

   property p_no_early;
      msg_accept && cfg_q[I_WAIT] != 16'h0000 |=> !tx_start [*2];
   endproperty
   a_no_early: assert property (p_no_early) else $error("reply too early");

   property p_lapse;
      lapse |=> comm_error;
   endproperty
   a_lapse: assert property (p_lapse) else $error("timeout not flagged");

   property p_trip;
      st_q == ST_RUN && lapse && cfg_q[I_ACT] == ACT_TRIP |=> ##1 trip_req;
   endproperty
   a_trip: assert property (p_trip) else $error("no trip on error");

   property p_ignore;
      st_q == ST_RUN && cfg_q[I_ACT] == ACT_IGN |=> st_q == ST_RUN;
   endproperty
   a_ignore: assert property (p_ignore) else $error("error not ignored");

   property p_zspd;
      out_freq <= cfg_q[I_ZERO] |=> zero_speed;
   endproperty
   a_zspd: assert property (p_zspd) else $error("zero speed missed");

   property p_therm;
      {9'h000, thermal_level} < cfg_q[I_THERM] |=> !thermal_warning_flag;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal warning early");

   property p_alm_off;
      cfg_q[I_ALARM] == 16'h0000 |=> alarm_out == 4'h0;
   endproperty
   a_alm_off: assert property (p_alm_off) else $error("alarm code shown");

   property p_test;
      cfg_q[I_BAUD] == BAUD_TEST [*2] |-> !baud_tick;
   endproperty
   a_test: assert property (p_test) else $error("tick in test mode");

   c_reply: cover property (msg_accept ##[1:1000] tx_start);
   c_refuse: cover property (reg_wr && !in_range);
   c_dtrip: cover property (st_q == ST_DECEL ##[1:50] st_q == ST_TRIP);
endmodule : sla_bank

// ==== bench/sla_master.sv ====
// network master model for the settings bank register port and message framing
// assumes the bench calls its tasks; it drives on the falling clock edge
`timescale 1ns/1ns
module sla_master (
   // clock
   input  wire logic        clock,
   // holding register port
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_ack,
   input  wire logic        reg_err,
   // message framing
   output logic             msg_valid,
   output logic [7:0]       msg_node
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      msg_valid = 1'b0;
      msg_node = 8'h00;
   end
   // whole word per access
   // released lines show the inverse, so a stale value never passes
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic k, output logic e);
      @(negedge clock);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      q = reg_rdata;
      k = reg_ack;
      e = reg_err;
   endtask : xfer
   // one complete message to a node
   task automatic msg(input logic [7:0] n);
      @(negedge clock);
      msg_valid = 1'b1;
      msg_node = n;
      @(negedge clock);
      msg_valid = 1'b0;
      msg_node = ~n;
   endtask : msg
endmodule : sla_master

// ==== bench/testbench.sv ====
// self-checking bench for the serial link and alarm settings bank
// assumes sla_master drives the register port; one 25 MHz clock
`timescale 1ns/1ns
module testbench;
   import sla_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic        clock, rst_n, reg_wr, reg_rd, reg_ack, reg_err, msg_valid, msg_accept, tx_start;
   logic        baud_tick, test_mode, data_bits8, two_stop, motor_stopped, trip_reset;
   logic        comm_error, trip_req, decel_req, coast_req, zero_speed, thermal_warning_flag, heatsink_warn;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, out_freq, scaled_voltage, scaled_current, scaled_second;
   logic [15:0] v;
   logic [7:0]  msg_node, heatsink_temp;
   logic [1:0]  parity_mode;
   logic [3:0]  trip_code, alarm_out;
   logic [6:0]  thermal_level;
   logic [11:0] ain_voltage, ain_current, ain_second;
   int          n_errors, compares, cyc, n;
   // short ms so reply wait and watchdog fit the run
   sla_bank #(.MS_CYC(10), .AIN_W(12)) u_sla_bank (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_ack, .reg_err, .msg_valid, .msg_node, .msg_accept, .tx_start, .baud_tick, .test_mode,
      .data_bits8, .parity_mode, .two_stop, .motor_stopped, .trip_reset, .comm_error, .trip_req, .decel_req,
      .coast_req, .trip_code, .alarm_out, .out_freq, .thermal_level, .heatsink_temp, .zero_speed,
      .thermal_warning_flag, .heatsink_warn, .ain_voltage, .ain_current, .ain_second, .scaled_voltage,
      .scaled_current, .scaled_second);
   sla_master u_sla_master (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
      .reg_err, .msg_valid, .msg_node);
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic e);
      logic [15:0] q;
      logic        k, f;
      u_sla_master.xfer(wr, a, d, q, k, f);
      chk(k, 1'b1);
      chk(f, e);
      // write data is don't-care; only read data is compared
      if (!wr) chk(q, e ? 16'h0000 : d);
   endtask : acc
   task automatic gap(output int g);
      g = 0;
      while (baud_tick !== 1'b1 && g < 12000) begin
         @(negedge clock);
         g++;
      end
      @(negedge clock);
      g = 1;
      while (baud_tick !== 1'b1 && g < 12000) begin
         @(negedge clock);
         g++;
      end
   endtask : gap
   function automatic logic [15:0] exp_alarm(input logic [15:0] f, input logic [3:0] c);
      return (f == ALM_4BIT) ? {12'h000, c} : (f == ALM_3BIT) ? {13'h0000, c[2:0]} : 16'h0000;
   endfunction : exp_alarm
   function automatic logic [15:0] exp_scale(input logic [11:0] x, input logic [15:0] s);
      logic [31:0] p;
      p = {20'h00000, x} * {16'h0000, s};
      return (p[31:28] != 4'h0) ? 16'hffff : p[27:12];
   endfunction : exp_scale
   // reaction levels as {trip, decel, coast}
   function automatic logic [15:0] exp_react(input logic [15:0] a, input logic st);
      case (a)
         ACT_TRIP:  return 16'h0004;
         ACT_DTRIP: return st ? 16'h0004 : 16'h0002;
         ACT_FREE:  return 16'h0001;
         ACT_DSTOP: return 16'h0002;
         default:   return 16'h0000;
      endcase
   endfunction : exp_react
   task automatic test_done;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   // ****************************************
   // clock and hang guard
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_errors++;
         test_done;
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_n, motor_stopped, trip_reset, trip_code, out_freq, thermal_level, heatsink_temp} = '0;
      {ain_voltage, ain_current, ain_second, n_errors, compares, cyc} = '0;
      void'($urandom(32'h6fba));
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      chk(data_bits8, 1'b1);
      for (int i = 0; i < NREG; i++) acc(0, REG_ADDR[i], REG_RST[i], 0);
      // lower bound, one step beyond each bound (below only where the lower bound is nonzero), a random legal value, then restore
      for (int i = 0; i < NREG; i++) begin
         v = REG_MIN[i] + 16'($urandom % (REG_MAX[i] - REG_MIN[i] + 1));
         acc(1, REG_ADDR[i], REG_MIN[i], 0);
         if (REG_MIN[i] != 0) acc(1, REG_ADDR[i], REG_MIN[i] - 1, 1);
         acc(0, REG_ADDR[i], REG_MIN[i], 0);
         acc(1, REG_ADDR[i], REG_MAX[i] + 1, 1);
         acc(1, REG_ADDR[i], v, 0);
         acc(0, REG_ADDR[i], v, 0);
         acc(1, REG_ADDR[i], REG_RST[i], 0);
      end
      acc(1, 16'h1454, 16'h0000, 1);
      acc(0, 16'h1440, 16'h0000, 1);
      acc(1, REG_ADDR[I_NODE], 16'h0005, 0);
      u_sla_master.msg(8'h06);
      chk(msg_accept, 1'b0);
      u_sla_master.msg(8'h05);
      chk(msg_accept, 1'b1);
      @(negedge clock);
      chk(tx_start, 1'b0);
      @(negedge clock);
      chk(tx_start, 1'b1);
      acc(1, REG_ADDR[I_NODE], 16'h0020, 0);
      acc(1, REG_ADDR[I_WAIT], 16'h0002, 0);
      u_sla_master.msg(8'h20);
      chk(msg_accept, 1'b1);
      for (n = 0; tx_start !== 1'b1 && n < 100; n++) @(negedge clock);
      chk(16'(n >= 20 && n <= 32), 16'h0001);
      acc(1, REG_ADDR[I_WAIT], 16'h0000, 0);
      acc(1, REG_ADDR[I_BAUD], BAUD_TEST, 0);
      @(negedge clock);
      chk(test_mode, 1'b1);
      n = 0;
      repeat (3000) begin
         @(negedge clock);
         if (baud_tick === 1'b1) n++;
      end
      chk(16'(n), 16'h0000);
      for (int b = 6; b >= 3; b--) begin
         acc(1, REG_ADDR[I_BAUD], 16'(b), 0);
         gap(n);
         gap(n);
         chk(16'(n), 16'(BIT_CYC << (6 - b)));
      end
      acc(1, REG_ADDR[I_DLEN], 16'h0007, 0);
      @(negedge clock);
      chk(data_bits8, 1'b0);
      acc(1, REG_ADDR[I_STOP], STOP_2, 0);
      @(negedge clock);
      chk(two_stop, 1'b1);
      for (int p = 0; p < 3; p++) begin
         acc(1, REG_ADDR[I_PAR], 16'(p), 0);
         @(negedge clock);
         chk(16'(parity_mode), 16'(p));
         acc(1, REG_ADDR[I_ALARM], 16'(p), 0);
         trip_code = 4'($urandom);
         repeat (2) @(negedge clock);
         chk(alarm_out, exp_alarm(16'(p), trip_code));
      end
      // thresholds: equal trips each flag, one below (one above for zero speed) does not
      repeat (4) begin
         v = 16'($urandom % 100 + 1);
         acc(1, REG_ADDR[I_THERM], v, 0);
         acc(1, REG_ADDR[I_HEAT], 16'(v * 2), 0);
         acc(1, REG_ADDR[I_ZERO], 16'(v * 99), 0);
         thermal_level = 7'(v);
         heatsink_temp = 8'(v * 2);
         out_freq = 16'(v * 99);
         // drive inputs are don't-care while no error is pending
         motor_stopped = 1'($urandom);
         trip_reset = 1'($urandom);
         repeat (2) @(negedge clock);
         chk({thermal_warning_flag, heatsink_warn, zero_speed}, 16'h0007);
         chk({trip_req, decel_req, coast_req}, 16'h0000);
         thermal_level = 7'(v - 1);
         heatsink_temp = 8'(v * 2 - 1);
         out_freq = 16'(v * 99 + 1);
         repeat (2) @(negedge clock);
         chk({thermal_warning_flag, heatsink_warn, zero_speed}, 16'h0000);
         v = (v == 4) ? 16'hfffa : 16'($urandom % 65531);
         {ain_voltage, ain_current, ain_second} = 36'($urandom) | 36'hfff;
         for (int k = 0; k < 3; k++) acc(1, REG_ADDR[I_SPAN0 + k], v, 0);
         repeat (3) @(negedge clock);
         chk(scaled_voltage, exp_scale(ain_voltage, v));
         chk(scaled_current, exp_scale(ain_current, v));
         chk(scaled_second, exp_scale(ain_second, v));
      end
      // each reaction: arm, clear by reset and a message, then go silent
      for (int a = 0; a < 5; a++) begin
         acc(1, REG_ADDR[I_ACT], 16'(a), 0);
         {trip_reset, motor_stopped} = 2'b10;
         u_sla_master.msg(8'h20);
         trip_reset = 1'b0;
         acc(1, REG_ADDR[I_TOUT], 16'h0001, 0);
         for (n = 0; comm_error !== 1'b1 && n < 400; n++) @(negedge clock);
         chk(16'(n >= 99 && n <= 201), 16'h0001);
         repeat (3) @(negedge clock);
         chk({trip_req, decel_req, coast_req}, exp_react(16'(a), 1'b0));
         motor_stopped = 1'b1;
         repeat (3) @(negedge clock);
         chk({trip_req, decel_req, coast_req}, exp_react(16'(a), 1'b1));
         acc(1, REG_ADDR[I_TOUT], 16'h0000, 0);
      end
      test_done;
   end
endmodule : testbench
